// File: logic/dog_config.sv
// Watchdog counter and diagnostic enable registers of the converter.
`default_nettype none
module dog_config
	import dog_pkg::*;
#(
	parameter int unsigned CYC_PER_MS_P = CYC_PER_MS
) (
	// Clock, reset, enable.
	input  wire logic        core_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        clk_en_in,
	// Register access from the serial decoder.
	input  wire logic        reg_wr_in,
	input  wire logic [4:0]  reg_addr_in,
	input  wire logic [15:0] reg_wdata_in,
	output logic      [21:0] reg_rdata_out,
	input  wire logic        good_command_in,
	input  wire logic        dog_restart_in,
	input  wire logic        expiry_clear_in,
	// Alarm pin.
	input  wire logic        dog_alarm_mask_in,
	input  wire logic        other_alarm_in,
	output logic             alarm_n_out,
	// Watchdog actions.
	output logic             dog_expiry_flag_out,
	output logic             clear_event_out,
	output logic             soft_reset_out,
	// Diagnostic enables and checks.
	output diag_cfg_t        diag_cfg_out,
	input  wire logic [15:0] dac_code_in,
	input  wire logic [15:0] latch_code_in,
	input  wire logic [15:0] inverse_code_in,
	output logic             latch_mismatch_flag_out,
	output logic             inverse_error_out,
	input  wire logic        latch_flag_clear_in
);
	dog_cfg_t   cfg_q;
	diag_cfg_t  diag_q;
	logic [31:0] count_q;
	logic        flag_q;
	logic        alarm_q;
	logic        latch_q;
	logic        inv_q;
	logic        restart;
	logic        expire;

	function automatic logic [31:0] period_cycles(input logic [3:0] code);
		logic [3:0] c;
		c = (code > CODE_MAX) ? CODE_DEFAULT : code;
		return 32'(PERIOD_MS[c] * CYC_PER_MS_P);
	endfunction

	function automatic logic [21:0] readback(input logic [4:0] loc,
		input logic [15:0] body);
		return {alarm_q, loc, body};
	endfunction

	// Register writes; reserved bits stay at zero.
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			cfg_q  <= dog_cfg_t'({SETUP_RESET[CLR_BIT], SETUP_RESET[RST_BIT],
				SETUP_RESET[KICK_BIT], SETUP_RESET[EN_BIT],
				SETUP_RESET[3:0]});
			diag_q <= diag_cfg_t'({DIAG_RESET[LATCH_BIT], DIAG_RESET[INV_BIT],
				DIAG_RESET[TRIM_BIT], DIAG_RESET[OSC_BIT],
				DIAG_RESET[LINK_BIT]});
		end else if (clk_en_in && reg_wr_in) begin
			if (reg_addr_in == SETUP_LOC) begin
				cfg_q <= dog_cfg_t'({reg_wdata_in[CLR_BIT],
					reg_wdata_in[RST_BIT], reg_wdata_in[KICK_BIT],
					reg_wdata_in[EN_BIT], reg_wdata_in[3:0]});
			end
			if (reg_addr_in == DIAG_LOC) begin
				diag_q <= diag_cfg_t'({reg_wdata_in[LATCH_BIT],
					reg_wdata_in[INV_BIT], reg_wdata_in[TRIM_BIT],
					reg_wdata_in[OSC_BIT], reg_wdata_in[LINK_BIT]});
			end
		end
	end

	// Writes to the setup register count as restart requests too, so that
	// enabling the dog always starts from a full period.
	assign restart = !flag_q && (dog_restart_in ||
		(cfg_q.restart_on_good_command && good_command_in) ||
		(reg_wr_in && reg_addr_in == SETUP_LOC));
	assign expire = cfg_q.dog_enable && !flag_q && count_q == 32'h1;

	// Down counter; stops once the flag is up.
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			count_q <= 32'h0;
		end else if (clk_en_in) begin
			if (!cfg_q.dog_enable || restart) begin
				count_q <= period_cycles(cfg_q.dog_period_code);
				if (reg_wr_in && reg_addr_in == SETUP_LOC) begin
					count_q <= period_cycles(reg_wdata_in[3:0]);
				end
			end else if (!flag_q && count_q != 32'h0) begin
				count_q <= count_q - 32'h1;
			end
		end
	end

	// Expiry flag: a new expiry wins over a clear in the same cycle.
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			flag_q <= 1'b0;
		end else if (clk_en_in) begin
			if (expire) begin
				flag_q <= 1'b1;
			end else if (expiry_clear_in) begin
				flag_q <= 1'b0;
			end
		end
	end

	// One-cycle action pulses on expiry.
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			clear_event_out <= 1'b0;
			soft_reset_out  <= 1'b0;
		end else if (clk_en_in) begin
			clear_event_out <= expire && cfg_q.clear_on_dog_expiry;
			soft_reset_out  <= expire && cfg_q.reset_on_dog_expiry;
		end
	end

	// Alarm pin, active low.
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			alarm_q <= 1'b0;
		end else if (clk_en_in) begin
			alarm_q <= (flag_q && !dog_alarm_mask_in) || other_alarm_in
				|| latch_q || inv_q;
		end
	end

	// Code checks; flags are sticky, set wins over clear.
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			latch_q <= 1'b0;
			inv_q   <= 1'b0;
		end else if (clk_en_in) begin
			if (diag_q.latch_monitor_enable && latch_code_in != dac_code_in) begin
				latch_q <= 1'b1;
			end else if (latch_flag_clear_in) begin
				latch_q <= 1'b0;
			end
			if (diag_q.inverse_check_enable
				&& inverse_code_in != ~dac_code_in) begin
				inv_q <= 1'b1;
			end else if (latch_flag_clear_in) begin
				inv_q <= 1'b0;
			end
		end
	end

	// Readback mux, registered.
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			reg_rdata_out <= 22'h0;
		end else if (clk_en_in) begin
			unique case (reg_addr_in)
				SETUP_LOC: reg_rdata_out <= readback(SETUP_LOC,
					{5'h0, cfg_q.clear_on_dog_expiry, cfg_q.reset_on_dog_expiry,
					cfg_q.restart_on_good_command, 1'b0, cfg_q.dog_enable,
					2'h0, cfg_q.dog_period_code});
				DIAG_LOC: reg_rdata_out <= readback(DIAG_LOC,
					{9'h0, diag_q.latch_monitor_enable, 1'b0,
					diag_q.inverse_check_enable, diag_q.trim_check_enable,
					diag_q.oscillator_rate_monitor_enable, 1'b0,
					diag_q.link_checksum_enable});
				default: reg_rdata_out <= readback(reg_addr_in, 16'h0);
			endcase
		end
	end

	// Trim checksum, rate monitor and link checksum act elsewhere from these.
	assign diag_cfg_out = diag_q;
	assign alarm_n_out = !alarm_q;
	assign dog_expiry_flag_out = flag_q;
	assign latch_mismatch_flag_out = latch_q;
	assign inverse_error_out = inv_q;

	chk_expiry_sets_flag: assert property (
		@(posedge core_clk_in)
		disable iff (!reset_n_in) clk_en_in && expire |=> flag_q)
		else $error("expiry did not set flag");
	// The count must hold still, whatever restart requests arrive.
	chk_flag_blocks_restart: assert property (
		@(posedge core_clk_in)
		disable iff (!reset_n_in) clk_en_in && flag_q && cfg_q.dog_enable
		|=> count_q == $past(count_q))
		else $error("restart while flag active");
	chk_clear_pulse: assert property (
		@(posedge core_clk_in)
		disable iff (!reset_n_in)
		clk_en_in && expire && cfg_q.clear_on_dog_expiry |=> clear_event_out)
		else $error("clear event missing");
	chk_reset_pulse: assert property (
		@(posedge core_clk_in)
		disable iff (!reset_n_in)
		clk_en_in && expire && cfg_q.reset_on_dog_expiry |=> soft_reset_out)
		else $error("soft reset missing");
	chk_alarm_from_flag: assert property (
		@(posedge core_clk_in)
		disable iff (!reset_n_in)
		clk_en_in && flag_q && !dog_alarm_mask_in |=> !alarm_n_out)
		else $error("alarm not driven");
	chk_readback_loc: assert property (
		@(posedge core_clk_in)
		disable iff (!reset_n_in) clk_en_in && reg_addr_in == SETUP_LOC
		|=> reg_rdata_out[LOC_HI:LOC_LO] == SETUP_LOC
		&& reg_rdata_out[PIN_BIT] == $past(alarm_q))
		else $error("readback location wrong");
	chk_period_clamp: assert property (
		@(posedge core_clk_in)
		period_cycles(4'hf) == period_cycles(CODE_DEFAULT))
		else $error("period clamp wrong");
	chk_latch_mismatch: assert property (
		@(posedge core_clk_in)
		disable iff (!reset_n_in) clk_en_in && diag_q.latch_monitor_enable
		&& latch_code_in != dac_code_in |=> latch_mismatch_flag_out)
		else $error("latch mismatch missed");
	chk_good_cmd_restart: assert property (
		@(posedge core_clk_in)
		disable iff (!reset_n_in) clk_en_in && cfg_q.dog_enable && !flag_q
		&& cfg_q.restart_on_good_command && good_command_in && !reg_wr_in
		|=> count_q == $past(period_cycles(cfg_q.dog_period_code)))
		else $error("good command did not restart");
endmodule // dog_config
`default_nettype wire

// File: common/dog_pkg.sv
// Package with register map, field positions and timing for the watchdog block.
`default_nettype none
package dog_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam logic [4:0] SETUP_LOC = 5'h0f;
	localparam logic [4:0] DIAG_LOC = 5'h10;
	localparam logic [21:0] SETUP_RESET = 22'h0f0009;
	localparam logic [21:0] DIAG_RESET = 22'h10005d;
	localparam int PIN_BIT = 21;
	localparam int LOC_HI = 20;
	localparam int LOC_LO = 16;
	localparam int CLR_BIT = 10;
	localparam int RST_BIT = 9;
	localparam int KICK_BIT = 8;
	localparam int EN_BIT = 6;
	localparam int LATCH_BIT = 6;
	localparam int INV_BIT = 4;
	localparam int TRIM_BIT = 3;
	localparam int OSC_BIT = 2;
	localparam int LINK_BIT = 0;
	localparam logic [15:0] SETUP_WMASK = 16'h0740;
	localparam logic [15:0] SETUP_PMASK = 16'h074f;
	localparam logic [15:0] DIAG_WMASK = 16'h005d;
	localparam logic [3:0] CODE_DEFAULT = 4'h9;
	localparam logic [3:0] CODE_MAX = 4'ha;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned PERIOD_MS [11] =
		'{1, 5, 10, 25, 50, 100, 250, 500, 750, 1000, 2000};
	typedef struct packed {
		logic clear_on_dog_expiry;
		logic reset_on_dog_expiry;
		logic restart_on_good_command;
		logic dog_enable;
		logic [3:0] dog_period_code;
	} dog_cfg_t;
	typedef struct packed {
		logic latch_monitor_enable;
		logic inverse_check_enable;
		logic trim_check_enable;
		logic oscillator_rate_monitor_enable;
		logic link_checksum_enable;
	} diag_cfg_t;
endpackage
`default_nettype wire

// File: verif/host_model.sv
// Host controller model that writes and reads the block's registers.
`default_nettype none
module host_model (
	// Clock.
	input  wire logic        core_clk_in,
	// Register access.
	output logic             reg_wr_out,
	output logic [4:0]       reg_addr_out,
	output logic [15:0]      reg_wdata_out,
	input  wire logic [21:0] reg_rdata_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_wr_out = 1'b0;
		reg_addr_out = 5'h00;
		reg_wdata_out = 16'h0000;
	end
	// Data is inverted once released so a stale value can never pass.
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk_in);
		#1;
		reg_wr_out = 1'b1;
		reg_addr_out = a;
		reg_wdata_out = d;
		@(posedge core_clk_in);
		#1;
		reg_wr_out = 1'b0;
		reg_wdata_out = ~d;
	endtask
	task automatic rd(input logic [4:0] a, output logic [21:0] d);
		@(posedge core_clk_in);
		#1;
		reg_addr_out = a;
		@(posedge core_clk_in);
		#1;
		d = reg_rdata_in;
	endtask
endmodule  // host_model
`default_nettype wire

// File: verif/dog_config_tb.sv
// Self-checking bench for the watchdog and diagnostic enables.
`default_nettype none
module dog_config_tb;
	import dog_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst_n = 1'b0, wr, gcmd = 1'b0, rsrt = 1'b0;
	logic        xclr = 1'b0, mask = 1'b0, lclr = 1'b0, saw_c, saw_r;
	logic        ce = 1'b1;
	logic [4:0]  addr;
	logic [15:0] wdata, d, dac = 16'h1234, lat = 16'h1234, inv = 16'hedcb;
	logic [21:0] rdata, rv;
	logic        alarm_n, flag, clr_ev, srst, lerr, ierr;
	diag_cfg_t   dcfg;
	logic [16:0] rnd = 17'd99587;
	int          failures = 0, num_checks = 0, cyc = 0, n;
	function automatic logic [16:0] lfsr(logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction
	// Expected cycles with one millisecond set to two cycles.
	function automatic int period(logic [3:0] c);
		return 2 * PERIOD_MS[(c > CODE_MAX) ? CODE_DEFAULT : c];
	endfunction
	task automatic chk(logic [21:0] seen, logic [21:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic tick(int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	host_model host (.core_clk_in(clk), .reg_wr_out(wr),
		.reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata));
	dog_config #(.CYC_PER_MS_P(2)) DUT (.core_clk_in(clk),
		.reset_n_in(rst_n), .clk_en_in(ce), .reg_wr_in(wr),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.good_command_in(gcmd), .dog_restart_in(rsrt),
		.expiry_clear_in(xclr), .dog_alarm_mask_in(mask),
		.other_alarm_in(1'b0), .alarm_n_out(alarm_n),
		.dog_expiry_flag_out(flag), .clear_event_out(clr_ev),
		.soft_reset_out(srst), .diag_cfg_out(dcfg), .dac_code_in(dac),
		.latch_code_in(lat), .inverse_code_in(inv),
		.latch_mismatch_flag_out(lerr), .inverse_error_out(ierr),
		.latch_flag_clear_in(lclr));
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (clr_ev === 1'b1) saw_c = 1'b1;
		if (srst === 1'b1) saw_r = 1'b1;
		if (cyc == 40000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		tick(4);
		rst_n = 1'b1;
		host.rd(SETUP_LOC, rv);
		chk(rv, SETUP_RESET);
		host.rd(DIAG_LOC, rv);
		chk(rv, DIAG_RESET);
		chk(dcfg, 5'h1f);
		host.rd(5'h05, rv);
		chk(rv, {1'b0, 5'h05, 16'h0000});
		lat = dac ^ 16'h0001;
		inv = dac;
		tick(3);
		chk({lerr, ierr}, 2'b11);
		lat = dac;
		inv = ~dac;
		lclr = 1'b1;
		tick(1);
		lclr = 1'b0;
		tick(2);
		chk({lerr, ierr}, 2'b00);
		host.wr(DIAG_LOC, 16'h0000);
		lat = ~dac;
		inv = dac;
		tick(3);
		chk({lerr, ierr, dcfg}, 7'h00);
		lat = dac;
		inv = ~dac;
		repeat (4) begin
			rnd = lfsr(rnd);
			d = rnd[15:0];
			host.wr(DIAG_LOC, d);
			host.rd(DIAG_LOC, rv);
			chk(rv[20:0], {DIAG_LOC, d & DIAG_WMASK});
			chk(dcfg, {d[6], d[4], d[3], d[2], d[0]});
		end
		host.wr(SETUP_LOC, 16'h0141);
		repeat (10) begin
			gcmd = 1'b1;
			tick(1);
			gcmd = 1'b0;
			tick(3);
		end
		chk(flag, 1'b0);
		tick(14);
		chk(flag, 1'b1);
		// Every code is run so the clamp above the top code is covered.
		for (int c = 0; c < 16; c++) begin
			rnd = lfsr(rnd);
			mask = rnd[0];
			d = {5'h00, rnd[1], c == 15, 1'b0, rnd[2], 1'b1, rnd[4:3], 4'(c)};
			xclr = 1'b1;
			tick(1);
			xclr = 1'b0;
			tick(2);
			chk(flag, 1'b0);
			saw_c = 1'b0;
			saw_r = 1'b0;
			host.wr(SETUP_LOC, d);
			n = 0;
			while (flag !== 1'b1 && n < 5000) begin
				tick(1);
				n++;
			end
			chk(n >= period(c) - 1 && n <= period(c) + 3, 1'b1);
			tick(1);
			chk({alarm_n, saw_c, saw_r}, {mask, d[10], d[9]});
			if (c != 15) begin
				host.rd(SETUP_LOC, rv);
				chk(rv, {~mask, SETUP_LOC, d & SETUP_PMASK});
				rsrt = 1'b1;
				tick(1);
				rsrt = 1'b0;
				host.wr(SETUP_LOC, d);
				tick(2);
				chk(flag, 1'b1);
				// A refused restart leaves the count empty, so no new expiry.
				if (c < 3) begin
					xclr = 1'b1;
					tick(1);
					xclr = 1'b0;
					tick(period(c) + 4);
					chk(flag, 1'b0);
				end
			end
		end
		xclr = 1'b1;
		tick(1);
		xclr = 1'b0;
		host.wr(SETUP_LOC, 16'h0041);
		repeat (6) begin
			rsrt = 1'b1;
			tick(1);
			rsrt = 1'b0;
			tick(5);
		end
		chk(flag, 1'b0);
		gcmd = 1'b1;
		tick(9);
		gcmd = 1'b0;
		chk(flag, 1'b1);
		xclr = 1'b1;
		tick(1);
		xclr = 1'b0;
		host.wr(SETUP_LOC, 16'h0041);
		ce = 1'b0;
		tick(30);
		chk(flag, 1'b0);
		ce = 1'b1;
		tick(12);
		chk(flag, 1'b1);
		xclr = 1'b1;
		tick(1);
		xclr = 1'b0;
		host.wr(SETUP_LOC, 16'h0000);
		tick(10);
		chk(flag, 1'b0);
		give_verdict();
	end
endmodule  // dog_config_tb
`default_nettype wire
